// ### core/adc_monitor_alarm_control.sv
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
module adc_monitor_alarm_control #(
    parameter logic [15:0] P_INIT_CONFIG = adc_mon_pkg::INIT_CONFIG,
    parameter logic [15:0] P_INIT_SEQ_LO = adc_mon_pkg::INIT_SEQ_LO,
    parameter logic [15:0] P_INIT_SEQ_HI = adc_mon_pkg::INIT_SEQ_HI,
    parameter logic [9:0] P_INIT_OT_UPPER = adc_mon_pkg::INIT_OT_UPPER,
    parameter logic [9:0] P_INIT_OT_LOWER = adc_mon_pkg::INIT_OT_LOWER
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_user_reset,
    input wire logic [6:0] i_port_reg_address,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_port_access_done,
    input wire logic i_jtag_rd,
    input wire logic [6:0] i_jtag_addr,
    output logic [15:0] o_jtag_rdata,
    input wire logic i_sample_trigger,
    input wire logic [9:0] i_adc_code,
    output logic [4:0] o_adc_channel,
    output logic o_conv_done,
    output logic o_sequence_done,
    output logic [2:0] o_alarm_outputs,
    output logic o_over_temp_alarm,
    output logic o_power_down,
    output logic o_irq
);
    localparam int RW = adc_mon_pkg::RES_W;
    localparam int DW = adc_mon_pkg::DATA_W;
    localparam int NS = adc_mon_pkg::NUM_SENS;

    logic [RW-1:0] res_r [adc_mon_pkg::NUM_CH];
    logic [RW-1:0] max_r [NS];
    logic [RW-1:0] min_r [NS];
    logic [RW-1:0] thr_r [adc_mon_pkg::NUM_THR];
    logic [DW-1:0] config_r, seq_lo_r, seq_hi_r;
    logic [adc_mon_pkg::IRQ_W-1:0] mask_r, stat_r, stat_nxt;
    logic [adc_mon_pkg::CH_W-1:0] chan_r;
    logic [NS-1:0] alarm_r;
    logic ot_r, trig_s1_r, trig_s2_r, trig_s3_r;
    logic sample, avg_valid;
    logic [RW-1:0] avg_result;

    localparam logic [31:0] CH_LEGAL = 32'hffff_000f;
    wire [31:0] seq_mask = {seq_hi_r, seq_lo_r} & CH_LEGAL;

    function automatic logic [4:0] next_channel(input logic [31:0] m, input logic [4:0] c);
        logic [4:0] n;
        logic [4:0] k;
        n = m[c] ? c : adc_mon_pkg::CH_TEMP;
        for (int i = adc_mon_pkg::NUM_CH - 1; i >= 1; i--) begin
            k = c + 5'(i);
            if (m[k]) begin
                n = k;
            end
        end
        return n;
    endfunction : next_channel

    function automatic logic [15:0] pad(input logic [9:0] v);
        return {{(DW - RW){1'b0}}, v};
    endfunction : pad

    wire [adc_mon_pkg::CH_W-1:0] chan_nxt = next_channel(seq_mask, chan_r);
    wire [DW-1:0] flags_word = pad({chan_r, o_power_down, ot_r, alarm_r});

    // address decode, shared with the test port
    function automatic logic [15:0] read_word(input logic [6:0] a);
        logic [15:0] w;
        w = '0;
        if (a < adc_mon_pkg::ADDR_MAX_BASE) begin
            w = pad(res_r[a[4:0]]);
        end else if (a - adc_mon_pkg::ADDR_MAX_BASE < 7'(NS)) begin
            w = pad(max_r[2'(a - adc_mon_pkg::ADDR_MAX_BASE)]);
        end else if (a - adc_mon_pkg::ADDR_MIN_BASE < 7'(NS)) begin
            w = pad(min_r[2'(a - adc_mon_pkg::ADDR_MIN_BASE)]);
        end else if (a == adc_mon_pkg::ADDR_IRQ_STAT) begin
            w = {12'h000, stat_r};
        end else if (a == adc_mon_pkg::ADDR_FLAGS) begin
            w = flags_word;
        end else if (a == adc_mon_pkg::ADDR_CONFIG) begin
            w = config_r;
        end else if (a == adc_mon_pkg::ADDR_IRQ_MASK) begin
            w = {12'h000, mask_r};
        end else if (a == adc_mon_pkg::ADDR_SEQ_LO) begin
            w = seq_lo_r;
        end else if (a == adc_mon_pkg::ADDR_SEQ_HI) begin
            w = seq_hi_r;
        end else if (a - adc_mon_pkg::ADDR_THR_BASE < 7'(adc_mon_pkg::NUM_THR)) begin
            w = pad(thr_r[3'(a - adc_mon_pkg::ADDR_THR_BASE)]);
        end
        return w;
    endfunction : read_word

    wire wr_cfg = i_wr && i_port_reg_address == adc_mon_pkg::ADDR_CONFIG;
    wire wr_mask = i_wr && i_port_reg_address == adc_mon_pkg::ADDR_IRQ_MASK;
    wire wr_seq_lo = i_wr && i_port_reg_address == adc_mon_pkg::ADDR_SEQ_LO;
    wire wr_seq_hi = i_wr && i_port_reg_address == adc_mon_pkg::ADDR_SEQ_HI;
    wire [6:0] thr_off = i_port_reg_address - adc_mon_pkg::ADDR_THR_BASE;
    wire wr_thr = i_wr && thr_off < 7'(adc_mon_pkg::NUM_THR);
    wire rd_stat = i_rd && i_port_reg_address == adc_mon_pkg::ADDR_IRQ_STAT;
    wire event_mode = config_r[adc_mon_pkg::CFG_EVENT];
    wire seq_wrap = avg_valid && chan_nxt <= chan_r;
    wire temp_hit = avg_valid && chan_r == adc_mon_pkg::CH_TEMP;
    wire ot_set = temp_hit && avg_result > thr_r[adc_mon_pkg::THR_OT];
    wire ot_clr = temp_hit &&
        avg_result < thr_r[adc_mon_pkg::THR_OT + adc_mon_pkg::THR_LO_OFS];
    wire [NS-1:0] alarm_set;
    wire [adc_mon_pkg::IRQ_W-1:0] irq_ev = {ot_set && !ot_r, |alarm_set, seq_wrap, avg_valid};

    // trigger is a pin: two flops first, then edge detect
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            trig_s1_r <= i_sample_trigger;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // sampling instants at the conversion rate
    conv_timer u_timer (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_event_mode(event_mode),
        .i_trigger(trig_s2_r && !trig_s3_r),
        .o_sample(sample)
    );

    sample_averager u_avg (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_clear(i_user_reset),
        .i_enable(config_r[adc_mon_pkg::CFG_AVG]),
        .i_sample(sample),
        .i_code(i_adc_code),
        .o_valid(avg_valid),
        .o_result(avg_result)
    );

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            config_r <= P_INIT_CONFIG;
            seq_lo_r <= P_INIT_SEQ_LO;
            seq_hi_r <= P_INIT_SEQ_HI;
            mask_r <= adc_mon_pkg::INIT_IRQ_MASK;
        end else begin
            if (wr_cfg) config_r <= i_wdata;
            if (wr_mask) mask_r <= i_wdata[adc_mon_pkg::IRQ_W-1:0];
            if (wr_seq_lo) seq_lo_r <= i_wdata;
            if (wr_seq_hi) seq_hi_r <= i_wdata;
        end
    end

    generate
        for (genvar t = 0; t < adc_mon_pkg::NUM_THR; t++) begin : g_thr
            localparam logic [9:0] T_INIT =
                (t == adc_mon_pkg::THR_OT) ? P_INIT_OT_UPPER :
                (t == adc_mon_pkg::THR_OT + adc_mon_pkg::THR_LO_OFS) ? P_INIT_OT_LOWER :
                (t < adc_mon_pkg::THR_LO_OFS) ? adc_mon_pkg::INIT_UPPER :
                adc_mon_pkg::INIT_LOWER;
            // limits default to 3ff upper and 000 lower, the over-temp pair to 125 C and 70 C, until rewritten
            always_ff @(posedge i_clock or negedge i_arst_n) begin
                if (!i_arst_n) thr_r[t] <= T_INIT;
                else if (wr_thr && thr_off[2:0] == 3'(t)) thr_r[t] <= i_wdata[RW-1:0];
            end
        end

        for (genvar c = 0; c < adc_mon_pkg::NUM_CH; c++) begin : g_res
            // result held until the same channel converts again
            always_ff @(posedge i_clock or negedge i_arst_n) begin
                if (!i_arst_n) res_r[c] <= '0;
                else if (avg_valid && chan_r == 5'(c)) res_r[c] <= avg_result;
            end
        end

        for (genvar s = 0; s < NS; s++) begin : g_sens
            wire hit = avg_valid && chan_r == 5'(s);
            assign alarm_set[s] = hit && !alarm_r[s] && (avg_result > thr_r[s] ||
                avg_result < thr_r[s + adc_mon_pkg::THR_LO_OFS]);
            always_ff @(posedge i_clock or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    max_r[s] <= '0;
                    min_r[s] <= '1;
                    alarm_r[s] <= 1'b0;
                end else if (i_user_reset) begin
                    max_r[s] <= '0;
                    min_r[s] <= '1;
                    alarm_r[s] <= 1'b0;
                end else if (hit) begin
                    if (avg_result > max_r[s]) max_r[s] <= avg_result;
                    if (avg_result < min_r[s]) min_r[s] <= avg_result;
                    // out of range raises the alarm
                    alarm_r[s] <= avg_result > thr_r[s] ||
                        avg_result < thr_r[s + adc_mon_pkg::THR_LO_OFS];
                end
            end
        end
    endgenerate

    // set wins over the read clear
    assign stat_nxt = (rd_stat ? '0 : stat_r) | irq_ev;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chan_r <= adc_mon_pkg::CH_TEMP;
            ot_r <= 1'b0;
            o_conv_done <= 1'b0;
            o_sequence_done <= 1'b0;
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
            // flags rise with the result store
            o_conv_done <= avg_valid;
            o_sequence_done <= seq_wrap;
            // step to the next selected channel
            if (i_user_reset) chan_r <= next_channel(seq_mask, 5'(adc_mon_pkg::NUM_CH - 1));
            else if (avg_valid) chan_r <= chan_nxt;
            // set above upper, hold until below lower
            if (i_user_reset || ot_clr) ot_r <= 1'b0;
            else if (ot_set) ot_r <= 1'b1;
        end
    end

    // access done and registered read data, test port read
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
            o_port_access_done <= 1'b0;
            o_jtag_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? read_word(i_port_reg_address) : '0;
            o_port_access_done <= i_rd || i_wr;
            // test port read never clears interrupt status
            if (i_jtag_rd) o_jtag_rdata <= read_word(i_jtag_addr);
        end
    end

    assign o_adc_channel = chan_r;
    assign o_alarm_outputs = alarm_r;
    assign o_over_temp_alarm = ot_r;
    // power-down follows the alarm when enabled
    assign o_power_down = ot_r && config_r[adc_mon_pkg::CFG_PD];
    assign o_irq = |(stat_r & mask_r);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    a_conv_store: assert property (
        avg_valid |=> o_conv_done && res_r[$past(chan_r)] == $past(avg_result))
        else $error("result not stored with done flag");
    a_seq_flag: assert property (
        o_sequence_done |-> o_conv_done) else $error("sequence done without conversion");
    a_seq_step: assert property (
        (avg_valid && seq_mask != 0 && !i_user_reset && !wr_seq_lo && !wr_seq_hi)
        |=> seq_mask[chan_r])
        else $error("sequencer left the selected set");
    a_max_track: assert property (
        (temp_hit && !i_user_reset) |=> max_r[0] >= $past(avg_result) && min_r[0] <= $past(avg_result))
        else $error("extremes not tracked");
    a_minmax_clear: assert property (
        i_user_reset |=> max_r[1] == '0 && min_r[1] == '1) else $error("records not cleared");
    a_alarm_range: assert property (
        (avg_valid && chan_r == adc_mon_pkg::CH_VCCINT && !i_user_reset &&
        avg_result > thr_r[1]) |=> o_alarm_outputs[1]) else $error("alarm missed");
    a_ot_set: assert property (
        (ot_set && !ot_clr && !i_user_reset) |=> o_over_temp_alarm) else $error("ot not set");
    a_ot_hold: assert property (
        (o_over_temp_alarm && !ot_clr && !i_user_reset) |=> o_over_temp_alarm)
        else $error("ot released early");
    a_pd_follow: assert property (
        (ot_set && !ot_clr && !i_user_reset && !wr_cfg && config_r[adc_mon_pkg::CFG_PD])
        |=> o_power_down) else $error("power-down missed while alarm active");
    a_cfg_write: assert property (
        wr_cfg |=> config_r == $past(i_wdata)) else $error("config write lost");
    a_access_done: assert property (
        (i_rd || i_wr) |=> o_port_access_done ##1 (o_port_access_done == $past(i_rd || i_wr)))
        else $error("access done missing");
    c_sequence: cover property (o_sequence_done);
    c_ot_cycle: cover property ($rose(o_over_temp_alarm) ##[1:1000] $fell(o_over_temp_alarm));
    c_irq: cover property ($rose(o_irq));
endmodule : adc_monitor_alarm_control

// ### core/conv_timer.sv
`timescale 1ns/1ns
module conv_timer (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_event_mode,
    input wire logic i_trigger,
    output logic o_sample
);
    adc_mon_pkg::conv_state_e state_r, state_nxt;
    logic [adc_mon_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic sample_nxt;
    wire last = cnt_r == adc_mon_pkg::CONV_LAST;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sample_nxt = 1'b0;
        unique case (state_r)
            adc_mon_pkg::CV_IDLE: begin
                cnt_nxt = '0;
                // triggers while busy are ignored
                if (!i_event_mode || i_trigger) begin
                    state_nxt = adc_mon_pkg::CV_BUSY;
                end
            end
            adc_mon_pkg::CV_BUSY: begin
                cnt_nxt = cnt_r + 1'b1;
                if (last) begin
                    sample_nxt = 1'b1;
                    cnt_nxt = '0;
                    if (i_event_mode) begin
                        state_nxt = adc_mon_pkg::CV_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = adc_mon_pkg::CV_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= adc_mon_pkg::CV_IDLE;
            cnt_r <= '0;
            o_sample <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            o_sample <= sample_nxt;
        end
    end

    a_sample_spacing: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_sample |-> ##1 !o_sample [*8]) else $error("samples closer than conversion time");
endmodule : conv_timer

// ### core/sample_averager.sv
`timescale 1ns/1ns
module sample_averager (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clear,
    input wire logic i_enable,
    input wire logic i_sample,
    input wire logic [adc_mon_pkg::RES_W-1:0] i_code,
    output logic o_valid,
    output logic [adc_mon_pkg::RES_W-1:0] o_result
);
    localparam int ACC_W = adc_mon_pkg::RES_W + adc_mon_pkg::AVG_SHIFT;
    localparam logic [adc_mon_pkg::AVG_SHIFT-1:0] N_LAST =
        adc_mon_pkg::AVG_SHIFT'(adc_mon_pkg::AVG_SAMPLES - 1);
    logic [ACC_W-1:0] acc_r;
    logic [adc_mon_pkg::AVG_SHIFT-1:0] n_r;
    wire [ACC_W-1:0] sum = acc_r + ACC_W'(i_code);
    wire done = i_sample && (!i_enable || n_r == N_LAST);
    wire [adc_mon_pkg::RES_W-1:0] avg = sum[ACC_W-1:adc_mon_pkg::AVG_SHIFT];

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            acc_r <= '0;
            n_r <= '0;
            o_valid <= 1'b0;
            o_result <= '0;
        end else begin
            o_valid <= done && !i_clear;
            if (i_clear || done || !i_enable) begin
                acc_r <= '0;
                n_r <= '0;
            end else if (i_sample) begin
                acc_r <= sum;
                n_r <= n_r + 1'b1;
            end
            if (done) begin
                o_result <= i_enable ? avg : i_code;
            end
        end
    end

    a_avg_bypass: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_sample && !i_enable && !i_clear) |=> o_valid && o_result == $past(i_code))
        else $error("unaveraged sample not passed through");
endmodule : sample_averager

// ### include/adc_mon_pkg.sv
package adc_mon_pkg;
    localparam int CLOCK_HZ = 100_000_000;
    localparam int MAX_RATE_SPS = 200_000;
    // least conversion period, rounded up to whole cycles
    localparam int CONV_CYCLES = (CLOCK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

    localparam int RES_W = 10;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int NUM_CH = 32;
    localparam int CH_W = 5;
    localparam int NUM_SENS = 3;
    localparam int NUM_THR = 8;
    localparam int THR_LO_OFS = 4;
    localparam int THR_OT = 3;
    localparam int AVG_SHIFT = 2;
    localparam int AVG_SAMPLES = 1 << AVG_SHIFT;

    localparam logic [CH_W-1:0] CH_TEMP = 5'h00;
    localparam logic [CH_W-1:0] CH_VCCINT = 5'h01;
    localparam logic [CH_W-1:0] CH_VCCAUX = 5'h02;
    localparam logic [CH_W-1:0] CH_VPVN = 5'h03;
    localparam logic [CH_W-1:0] CH_AUX0 = 5'h10;

    localparam logic [ADDR_W-1:0] ADDR_RES_BASE = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_MAX_BASE = 7'h20;
    localparam logic [ADDR_W-1:0] ADDR_MIN_BASE = 7'h24;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 7'h3e;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 7'h3f;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 7'h40;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 7'h41;
    localparam logic [ADDR_W-1:0] ADDR_SEQ_LO = 7'h48;
    localparam logic [ADDR_W-1:0] ADDR_SEQ_HI = 7'h49;
    localparam logic [ADDR_W-1:0] ADDR_THR_BASE = 7'h50;

    localparam int CFG_AVG = 0;
    localparam int CFG_EVENT = 1;
    localparam int CFG_PD = 2;

    localparam int IRQ_W = 4;
    localparam int IRQ_CONV = 0;
    localparam int IRQ_SEQ = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_OT = 3;

    localparam logic [DATA_W-1:0] INIT_CONFIG = 16'h0000;
    localparam logic [DATA_W-1:0] INIT_SEQ_LO = 16'h0007;
    localparam logic [DATA_W-1:0] INIT_SEQ_HI = 16'h0000;
    localparam logic [IRQ_W-1:0] INIT_IRQ_MASK = 4'h0;
    // 125 C upper and 70 C release point, temperature code scale
    localparam logic [RES_W-1:0] INIT_OT_UPPER = 10'h329;
    localparam logic [RES_W-1:0] INIT_OT_LOWER = 10'h2b9;
    localparam logic [RES_W-1:0] INIT_UPPER = 10'h3ff;
    localparam logic [RES_W-1:0] INIT_LOWER = 10'h000;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_BUSY = 2'b10
    } conv_state_e;
endpackage : adc_mon_pkg

// ### verif/afe_model.sv
`timescale 1ns/1ns
module afe_model (
    input wire logic [4:0] i_channel,
    input wire logic [9:0] i_temp_code,
    output logic [9:0] o_code
);
    // sensor and pair codes
    // fixed codes per channel except the temperature channel, so a wrong mux select shows up as a wrong result
    always_comb begin
        case (i_channel)
            5'h00: o_code = i_temp_code;
            5'h01: o_code = 10'h150;
            5'h02: o_code = 10'h160;
            5'h03: o_code = 10'h0a0;
            default: o_code = {5'h04, i_channel};
        endcase
    end
endmodule : afe_model

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
    logic i_clock, i_arst_n, i_user_reset, i_wr, i_rd, i_jtag_rd;
    logic [6:0] i_port_reg_address, i_jtag_addr;
    logic [15:0] i_wdata, o_rdata, o_jtag_rdata, rd_word;
    logic [9:0] adc_code, temp_code;
    logic [4:0] adc_channel;
    logic [2:0] o_alarm_outputs;
    logic o_port_access_done, o_conv_done, o_sequence_done, o_over_temp_alarm;
    logic o_power_down, o_irq, sample_trigger;
    int fail_count, checks;
    int seen;
    localparam int AVG_PERIOD = adc_mon_pkg::CONV_CYCLES * adc_mon_pkg::AVG_SAMPLES;
    // two sync flops, idle exit, averager and store stages after the pin rises
    localparam int EVENT_LAT = adc_mon_pkg::CONV_CYCLES + 5;

    afe_model fe (.i_channel(adc_channel), .i_temp_code(temp_code), .o_code(adc_code));

    adc_monitor_alarm_control DUT (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_user_reset(i_user_reset),
        .i_port_reg_address(i_port_reg_address), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_port_access_done(o_port_access_done),
        .i_jtag_rd(i_jtag_rd), .i_jtag_addr(i_jtag_addr), .o_jtag_rdata(o_jtag_rdata),
        .i_sample_trigger(sample_trigger), .i_adc_code(adc_code),
        .o_adc_channel(adc_channel),
        .o_conv_done(o_conv_done), .o_sequence_done(o_sequence_done),
        .o_alarm_outputs(o_alarm_outputs), .o_over_temp_alarm(o_over_temp_alarm),
        .o_power_down(o_power_down), .o_irq(o_irq)
    );

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_port_reg_address <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        #1 cmp("write done", 16'h0001, {15'h0000, o_port_access_done});
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_port_reg_address <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 cmp("read done", 16'h0001, {15'h0000, o_port_access_done});
        cmp($sformatf("reg %h", a), exp, o_rdata);
    endtask : rdchk

    // waits on whole sequences so every channel sees the new analog value
    task automatic wait_seq(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge i_clock);
                #1 k++;
            end while (o_sequence_done !== 1'b1 && k < 3000);
            if (k >= 3000) cmp("sequence done", 16'h0001, 16'h0000);
        end
    endtask : wait_seq

    // counts edges until the next stored result, limit 3000
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge i_clock);
            #1 n++;
        end while (o_conv_done !== 1'b1 && n < 3000);
    endtask : wait_done

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    initial begin
        // every wait running to its limit still ends before this
        #600000;
        fail_count++;
        final_report();
    end

    initial begin
        i_arst_n = 1'b0;
        i_user_reset = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_jtag_rd = 1'b0;
        i_jtag_addr = 7'h00;
        i_port_reg_address = 7'h00;
        i_wdata = 16'h0000;
        temp_code = 10'h200;
        sample_trigger = 1'b0;
        repeat (4) @(posedge i_clock);
        i_arst_n <= 1'b1;
        rdchk(7'h40, 16'h0000);
        rdchk(7'h48, 16'h0007);
        rdchk(7'h53, 16'h0329);
        rdchk(7'h24, 16'h03ff);
        rdchk(7'h7f, 16'h0000);
        wr(7'h41, 16'h0004);
        rdchk(7'h41, 16'h0004);
        wr(7'h51, 16'h0100);
        wait_seq(2);
        rdchk(7'h00, 16'h0200);
        rdchk(7'h01, 16'h0150);
        rdchk(7'h02, 16'h0160);
        cmp("alarm", 16'h0002, {13'h0000, o_alarm_outputs});
        cmp("irq set", 16'h0001, {15'h0000, o_irq});
        rdchk(7'h3e, 16'h0007);
        cmp("irq clear", 16'h0000, {15'h0000, o_irq});
        wr(7'h51, 16'h03ff);
        wr(7'h40, 16'h0004);
        temp_code = 10'h340;
        wait_seq(2);
        cmp("hot", 16'h0001, {15'h0000, o_over_temp_alarm});
        cmp("power down", 16'h0001, {15'h0000, o_power_down});
        rdchk(7'h20, 16'h0340);
        temp_code = 10'h2c0;
        wait_seq(2);
        cmp("hot held", 16'h0001, {15'h0000, o_over_temp_alarm});
        temp_code = 10'h2a0;
        wait_seq(2);
        cmp("hot released", 16'h0000, {15'h0000, o_over_temp_alarm});
        cmp("powered up", 16'h0000, {15'h0000, o_power_down});
        @(posedge i_clock);
        i_jtag_rd <= 1'b1;
        @(posedge i_clock);
        i_jtag_rd <= 1'b0;
        #1 cmp("test port", 16'h02a0, o_jtag_rdata);
        // land the user reset right after a result so no sample falls before the reads
        wait_seq(1);
        @(posedge i_clock);
        i_user_reset <= 1'b1;
        @(posedge i_clock);
        i_user_reset <= 1'b0;
        rdchk(7'h20, 16'h0000);
        rdchk(7'h24, 16'h03ff);
        wr(7'h48, 16'h0001);
        wr(7'h40, 16'h0001);
        wait_seq(1);
        wait_done(seen);
        cmp("avg period", 16'(AVG_PERIOD), 16'(seen));
        cmp("channel", 16'h0000, {11'h000, adc_channel});
        rdchk(7'h00, 16'h02a0);
        wr(7'h40, 16'h0002);
        repeat (600) @(posedge i_clock);
        sample_trigger <= 1'b1;
        wait_done(seen);
        cmp("event latency", 16'(EVENT_LAT), 16'(seen));
        @(posedge i_clock);
        sample_trigger <= 1'b0;
        seen = 0;
        repeat (1100) begin
            @(posedge i_clock);
            #1 if (o_conv_done !== 1'b0) seen++;
        end
        cmp("event quiet", 16'h0000, 16'(seen));
        final_report();
    end
endmodule : tb
